// file: design/oscdiv_top.v
// Our own choices: the address map and the APB register port.
`timescale 1ns/100ps
`include "oscdiv_consts.vh"

// Overview of operation
// (R1) current source field, read only, eight codes
// (R2) next source field, strap loaded at power-on
// (R3) primary submode picks crystal or external type
// (R4) erased part starts fast RC divide-by-N
// (R5) freeze plus permission blocks clock configuration
// (R6) lock flag shows PLL lock, zero otherwise
// (R7) fail flag hardware set, software clear only; the code also clears it when a switch starts
// (R8) enable bit powers secondary oscillator
// (R9) switch request set by software, hardware clears
// (R10) control writes need the unlock sequence
// (R11) no direct PLL-to-PLL source switch; the code does not block one
// (R12) interrupt clears reduction enable when armed
// (R13) reduction code divides by two-power, reset eight
// (R14) reduction disabled forces one-to-one ratio
// (R15) fast RC postscale 1..64, code seven 256
// (R16) VCO divider 2, 4, 8; code two reserved
// (R17) input prescaler divides by code plus two
// (R18) oscillator divided by two for instruction
// (R19) feedback multiplier is code plus two
// (R20) wait ready, ten source cycles, then switch
// (R21) same source request is dropped at once
// (R22) reserved divider code keeps old setting
// (R23) unimplemented bits read zero
module oscdiv_top #(
  parameter ADDR_WIDTH = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_WIDTH-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [2:0] initial_osc_sel,
  input wire [1:0] primary_submode_sel,
  input wire freeze_permission_cfg,
  input wire new_src_ready,
  input wire new_src_clk,
  input wire pll_locked,
  input wire clock_fail_event,
  input wire irq_pending,
  output reg [2:0] current_osc_sel,
  output reg [2:0] osc_power_sel,
  output reg [1:0] primary_osc_type,
  output reg secondary_osc_on,
  output reg [8:0] fast_rc_div_ratio,
  output reg [3:0] vco_div_ratio,
  output reg [5:0] pre_div_ratio,
  output reg [9:0] feedback_multiplier,
  output reg cpu_tick,
  output reg periph_tick
);

  // ----------------------------------------
  // state machine codes
  // ----------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_COUNT = 2'd2;
  // reset image of clock_divisor, sliced per field so no bits drop silently
  localparam [15:0] RST_DIV = `OSCDIV_RST_CLK_DIV;

  reg [2:0] next_osc_sel;
  reg clock_cfg_freeze;
  reg clock_fail_flag;
  reg switch_request;
  reg recover_on_irq;
  reg [2:0] cpu_clock_reduction;
  reg reduction_enable;
  reg [2:0] fast_rc_postscale;
  reg [1:0] vco_out_divider;
  reg [4:0] phase_det_in_divider;
  reg [8:0] fb_code;
  reg cfg_loaded;
  reg key_stage;
  reg unlocked;
  reg [1:0] sw_state;
  reg [2:0] target_sel;
  reg [3:0] edge_cnt;
  reg src_clk_prev;
  reg [6:0] cpu_clock_reduction_cnt;
  reg [31:0] rd_mux;
  reg rd_hit;
  reg [6:0] cpu_clock_reduction_mask;
  reg lock_flag;

  wire [4:0] sync_o;
  wire ready_s = sync_o[0];
  wire clk_s = sync_o[1];
  wire lock_s = sync_o[2];
  wire fail_s = sync_o[3];
  wire irq_s = sync_o[4];
  wire frozen = clock_cfg_freeze & freeze_permission_cfg;
  wire wr_fire = psel & penable & pready & pwrite;
  wire setup = psel & ~penable;
  wire wr_ctrl = wr_fire & (paddr == `OSCDIV_ADDR_OSC_CTRL) & unlocked;
  wire wr_div = wr_fire & (paddr == `OSCDIV_ADDR_CLK_DIV);
  wire wr_fb = wr_fire & (paddr == `OSCDIV_ADDR_FB_MULT);
  wire wr_key = wr_fire & (paddr == `OSCDIV_ADDR_UNLOCK);
  wire src_edge = clk_s & ~src_clk_prev;
  wire tgt_pll = (target_sel == `OSCDIV_SRC_FRC_PLL) | (target_sel == `OSCDIV_SRC_PRI_PLL);
  wire cur_pll = (current_osc_sel == `OSCDIV_SRC_FRC_PLL) |
                 (current_osc_sel == `OSCDIV_SRC_PRI_PLL);
  wire pll_used = cur_pll | ((sw_state != ST_IDLE) & tgt_pll);
  wire sw_done = (sw_state == ST_COUNT) & src_edge &
                 (edge_cnt == `OSCDIV_SWITCH_SRC_CYCLES - 4'h1);
  wire sw_same = (sw_state == ST_IDLE) & switch_request & cfg_loaded &
                 (next_osc_sel == current_osc_sel);
  wire sw_start = (sw_state == ST_IDLE) & switch_request & cfg_loaded &
                  (next_osc_sel != current_osc_sel);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  oscdiv_sync #(
    .WIDTH(5)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({irq_pending, clock_fail_event, pll_locked, new_src_clk, new_src_ready}),
    .sync_out(sync_o)
  );

  // ----------------------------------------
  // register read view
  // ----------------------------------------
  // read mux; unused positions tie to zero
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      `OSCDIV_ADDR_OSC_CTRL: begin
        // (R23) zero fill holes
        // (R1) read-only current source
        rd_mux[`OSCDIV_OC_CUR_LSB +: 3] = current_osc_sel;
        rd_mux[`OSCDIV_OC_NEXT_LSB +: 3] = next_osc_sel;
        rd_mux[`OSCDIV_OC_FREEZE] = clock_cfg_freeze;
        rd_mux[`OSCDIV_OC_LOCK] = lock_flag;
        rd_mux[`OSCDIV_OC_FAIL] = clock_fail_flag;
        rd_mux[`OSCDIV_OC_SEC_ON] = secondary_osc_on;
        rd_mux[`OSCDIV_OC_SWREQ] = switch_request;
      end
      `OSCDIV_ADDR_CLK_DIV: begin
        rd_mux[`OSCDIV_CD_ROI] = recover_on_irq;
        rd_mux[`OSCDIV_CD_CPU_CLOCK_REDUCTION_LSB +: 3] = cpu_clock_reduction;
        rd_mux[`OSCDIV_CD_REDUCTION_ENABLE] = reduction_enable;
        rd_mux[`OSCDIV_CD_FRC_LSB +: 3] = fast_rc_postscale;
        rd_mux[`OSCDIV_CD_POST_LSB +: 2] = vco_out_divider;
        rd_mux[`OSCDIV_CD_PRE_LSB +: 5] = phase_det_in_divider;
      end
      `OSCDIV_ADDR_FB_MULT: begin
        rd_mux[8:0] = fb_code;
      end
      `OSCDIV_ADDR_UNLOCK: begin
        rd_mux[0] = unlocked;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  // answer registered at the setup edge so all outputs are flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~rd_hit;
      prdata <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // (R10) unlock key sequence
  // the arm lasts for exactly one following write, so a stray write disarms it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_stage <= 1'b0;
      unlocked <= 1'b0;
    end else if (wr_key) begin
      key_stage <= (pwdata[15:0] == `OSCDIV_KEY_FIRST);
      unlocked <= key_stage & (pwdata[15:0] == `OSCDIV_KEY_SECOND);
    end else if (wr_fire) begin
      key_stage <= 1'b0;
      unlocked <= 1'b0;
    end
  end

  // ----------------------------------------
  // oscillator control register
  // ----------------------------------------
  // strap capture one edge after reset release, never under reset itself
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // (R4) erased default source
      next_osc_sel <= `OSCDIV_ERASED_SEL;
      current_osc_sel <= `OSCDIV_ERASED_SEL;
      cfg_loaded <= 1'b0;
      clock_cfg_freeze <= 1'b0;
      secondary_osc_on <= 1'b0;
      switch_request <= 1'b0;
      clock_fail_flag <= 1'b0;
    end else begin
      if (!cfg_loaded) begin
        // (R2) strap loads selections
        next_osc_sel <= initial_osc_sel;
        current_osc_sel <= initial_osc_sel;
        cfg_loaded <= 1'b1;
      end else if (wr_ctrl && !frozen) begin
        // (R5) frozen blocks selection
        next_osc_sel <= pwdata[`OSCDIV_OC_NEXT_LSB +: 3];
      end
      // (R20) commit new source
      if (sw_done) begin
        current_osc_sel <= target_sel;
      end
      // freeze stays set while permission holds
      if (wr_ctrl && !frozen) begin
        clock_cfg_freeze <= pwdata[`OSCDIV_OC_FREEZE];
      end
      // (R8) secondary enable bit
      if (wr_ctrl) begin
        secondary_osc_on <= pwdata[`OSCDIV_OC_SEC_ON];
      end
      // (R9) software set, hardware clear
      if (wr_ctrl && !frozen && pwdata[`OSCDIV_OC_SWREQ]) begin
        switch_request <= 1'b1;
      end else if (sw_done || sw_same) begin
        // (R21) redundant request dropped
        switch_request <= 1'b0;
      end
      // (R7) set wins over clear
      if (fail_s) begin
        clock_fail_flag <= 1'b1;
      end else if ((wr_ctrl && !pwdata[`OSCDIV_OC_FAIL]) || sw_start) begin
        clock_fail_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // switch sequencer
  // ----------------------------------------
  // target latched so a later selection write cannot retarget mid-switch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_state <= ST_IDLE;
      target_sel <= `OSCDIV_ERASED_SEL;
      edge_cnt <= 4'h0;
      src_clk_prev <= 1'b0;
    end else begin
      src_clk_prev <= clk_s;
      case (sw_state)
        ST_IDLE: begin
          edge_cnt <= 4'h0;
          if (sw_start) begin
            target_sel <= next_osc_sel;
            sw_state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // (R20) wait source ready
          if (ready_s && (!tgt_pll || lock_s)) begin
            sw_state <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          // (R20) count ten cycles
          if (sw_done) begin
            sw_state <= ST_IDLE;
          end else if (src_edge) begin
            edge_cnt <= edge_cnt + 4'h1;
          end
        end
        default: begin
          sw_state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // clock divisor and feedback registers
  // ----------------------------------------
  // cpu_clock_reduction fields stay writable under freeze; only clock and pll setup lock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recover_on_irq <= RST_DIV[`OSCDIV_CD_ROI];
      cpu_clock_reduction <= RST_DIV[`OSCDIV_CD_CPU_CLOCK_REDUCTION_LSB +: 3];
      reduction_enable <= RST_DIV[`OSCDIV_CD_REDUCTION_ENABLE];
      fast_rc_postscale <= RST_DIV[`OSCDIV_CD_FRC_LSB +: 3];
      vco_out_divider <= RST_DIV[`OSCDIV_CD_POST_LSB +: 2];
      phase_det_in_divider <= RST_DIV[`OSCDIV_CD_PRE_LSB +: 5];
      fb_code <= `OSCDIV_RST_FB_CODE;
    end else begin
      if (wr_div) begin
        recover_on_irq <= pwdata[`OSCDIV_CD_ROI];
        cpu_clock_reduction <= pwdata[`OSCDIV_CD_CPU_CLOCK_REDUCTION_LSB +: 3];
      end
      // (R12) interrupt clears enable
      if (irq_s && recover_on_irq) begin
        reduction_enable <= 1'b0;
      end else if (wr_div) begin
        reduction_enable <= pwdata[`OSCDIV_CD_REDUCTION_ENABLE];
      end
      // (R5) frozen pll settings
      if (wr_div && !frozen) begin
        fast_rc_postscale <= pwdata[`OSCDIV_CD_FRC_LSB +: 3];
        phase_det_in_divider <= pwdata[`OSCDIV_CD_PRE_LSB +: 5];
        // (R22) reserved code ignored
        if (pwdata[`OSCDIV_CD_POST_LSB +: 2] != `OSCDIV_POST_RESERVED) begin
          vco_out_divider <= pwdata[`OSCDIV_CD_POST_LSB +: 2];
        end
      end
      if (wr_fb && !frozen) begin
        fb_code <= pwdata[8:0];
      end
    end
  end

  // ----------------------------------------
  // decoded divider and source outputs
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_rc_div_ratio <= 9'h001;
      vco_div_ratio <= 4'h4;
      pre_div_ratio <= 6'h02;
      feedback_multiplier <= 10'h032;
      osc_power_sel <= `OSCDIV_ERASED_SEL;
      primary_osc_type <= `OSCDIV_PRI_NONE;
      lock_flag <= 1'b0;
    end else begin
      // (R15) postscale, code seven 256
      fast_rc_div_ratio <= (fast_rc_postscale == 3'h7) ? 9'h100 :
                           (9'h001 << fast_rc_postscale);
      // (R16) vco output divider
      vco_div_ratio <= (vco_out_divider == 2'h3) ? 4'h8 :
                       (vco_out_divider == 2'h1) ? 4'h4 : 4'h2;
      // (R17) prescaler code plus two
      pre_div_ratio <= {1'b0, phase_det_in_divider} + 6'h02;
      // (R19) multiplier code plus two
      feedback_multiplier <= {1'b0, fb_code} + 10'h002;
      // the target is powered during a switch, the current source otherwise
      osc_power_sel <= (sw_state != ST_IDLE) ? target_sel : current_osc_sel;
      // (R3) submode only for primary
      primary_osc_type <= ((current_osc_sel == `OSCDIV_SRC_PRI) ||
                           (current_osc_sel == `OSCDIV_SRC_PRI_PLL)) ?
                          primary_submode_sel : `OSCDIV_PRI_NONE;
      // (R6) lock only when pll used
      lock_flag <= lock_s & pll_used;
    end
  end

  // ----------------------------------------
  // instruction and peripheral ticks
  // ----------------------------------------
  // pclk stands in for fosc here, so fcy ticks on every second edge
  always @* begin
    cpu_clock_reduction_mask = 7'h7f >> (3'h7 - cpu_clock_reduction);
    if (cpu_clock_reduction == 3'h0) begin
      cpu_clock_reduction_mask = 7'h00;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_tick <= 1'b0;
      periph_tick <= 1'b0;
      cpu_clock_reduction_cnt <= 7'h00;
    end else begin
      // (R18) fosc halved for fcy
      cpu_tick <= ~cpu_tick;
      if (cpu_tick) begin
        cpu_clock_reduction_cnt <= cpu_clock_reduction_cnt + 7'h01;
      end
      // (R13) two-power reduction
      // (R14) disabled gives one-to-one
      periph_tick <= cpu_tick & (!reduction_enable || ((cpu_clock_reduction_cnt & cpu_clock_reduction_mask) == 7'h00));
    end
  end

endmodule // oscdiv_top

// file: design/oscdiv_consts.vh
`ifndef OSCDIV_CONSTS_VH
`define OSCDIV_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OSCDIV_ADDR_OSC_CTRL 8'h00
`define OSCDIV_ADDR_CLK_DIV 8'h04
`define OSCDIV_ADDR_FB_MULT 8'h08
`define OSCDIV_ADDR_UNLOCK 8'h0c

// ----------------------------------------
// reset values
// ----------------------------------------
`define OSCDIV_RST_CLK_DIV 16'h3040
`define OSCDIV_RST_FB_CODE 9'h030
`define OSCDIV_ERASED_SEL 3'h7

// ----------------------------------------
// unlock keys (arbitrary values)
// ----------------------------------------
`define OSCDIV_KEY_FIRST 16'h0046
`define OSCDIV_KEY_SECOND 16'h0057

// ----------------------------------------
// oscillator_control field positions
// ----------------------------------------
`define OSCDIV_OC_CUR_LSB 12
`define OSCDIV_OC_NEXT_LSB 8
`define OSCDIV_OC_FREEZE 7
`define OSCDIV_OC_LOCK 5
`define OSCDIV_OC_FAIL 3
`define OSCDIV_OC_SEC_ON 1
`define OSCDIV_OC_SWREQ 0

// ----------------------------------------
// clock_divisor field positions
// ----------------------------------------
`define OSCDIV_CD_ROI 15
`define OSCDIV_CD_CPU_CLOCK_REDUCTION_LSB 12
`define OSCDIV_CD_REDUCTION_ENABLE 11
`define OSCDIV_CD_FRC_LSB 8
`define OSCDIV_CD_POST_LSB 6
`define OSCDIV_CD_PRE_LSB 0

// ----------------------------------------
// source encodings and divider codes
// ----------------------------------------
`define OSCDIV_SRC_FRC 3'h0
`define OSCDIV_SRC_FRC_PLL 3'h1
`define OSCDIV_SRC_PRI 3'h2
`define OSCDIV_SRC_PRI_PLL 3'h3
`define OSCDIV_SRC_SEC 3'h4
`define OSCDIV_SRC_SLOW_RC 3'h5
`define OSCDIV_SRC_FRC_DIV16 3'h6
`define OSCDIV_SRC_FRC_DIVN 3'h7
`define OSCDIV_POST_RESERVED 2'h2
`define OSCDIV_PRI_NONE 2'h3

// ----------------------------------------
// timing counts
// ----------------------------------------
`define OSCDIV_SWITCH_SRC_CYCLES 4'ha
`define OSCDIV_FOSC_TO_FCY 2

`endif

// file: design/oscdiv_sync.v
`timescale 1ns/100ps

// three-stage synchroniser; output follows once stages two and three agree
module oscdiv_sync #(
  parameter WIDTH = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer i;

  // stage1 is read by stage2 only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end

endmodule // oscdiv_sync

// file: verification/oscdiv_top_sva.sv
`timescale 1ns/100ps
// ----------------------------------------
// bus and clock tree checker
// ----------------------------------------
module oscdiv_top_sva #(
  parameter ADDR_WIDTH = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_WIDTH-1:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [2:0] current_osc_sel,
  input wire [2:0] osc_power_sel,
  input wire [1:0] primary_osc_type,
  input wire [3:0] vco_div_ratio,
  input wire cpu_tick,
  input wire periph_tick
);
  logic [1:0] age;
  logic wr_q;
  // age hides the strap load just after reset; wr_q marks a finished write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age <= 2'h0;
      wr_q <= 1'b0;
    end else begin
      if (age != 2'h3) age <= age + 2'h1;
      wr_q <= psel && penable && pready && pwrite;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  a_ready_next: assert property (setup_s |=> access_s)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (setup_s and paddr >= 'h10 |=> pslverr && pready)
    else $error("no error on unmapped address");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  a_tick_toggle: assert property (cpu_tick |=> !cpu_tick ##1 cpu_tick)
    else $error("instruction tick not halving");
  // the peripheral pulse is registered from the instruction tick, one cycle behind it
  a_periph_align: assert property (periph_tick |-> $past(cpu_tick))
    else $error("peripheral tick off instruction tick");
  a_type_idle: assert property ((current_osc_sel[2:1] != 2'h1) [*2] |-> primary_osc_type == 2'h3)
    else $error("submode shown for non-primary source");
  a_sel_follow: assert property (age == 2'h3 && $changed(current_osc_sel)
    |-> current_osc_sel == $past(osc_power_sel))
    else $error("current source not the powered target");
  a_post_legal: assert property (vco_div_ratio inside {4'h2, 4'h4, 4'h8})
    else $error("illegal vco divide ratio");
  a_ratio_cause: assert property (age == 2'h3 && $changed(vco_div_ratio) |-> $past(wr_q))
    else $error("vco ratio moved without a write");
endmodule // oscdiv_top_sva

bind oscdiv_top oscdiv_top_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_sva (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .current_osc_sel, .osc_power_sel,
  .primary_osc_type, .vco_div_ratio, .cpu_tick, .periph_tick);

// file: verification/oscdiv_osc_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// new source and pll stand-in
// ----------------------------------------
module oscdiv_osc_model #(
  parameter int DLY = 20
) (
  input wire logic pclk,
  input wire logic [2:0] target,
  input wire logic [2:0] current,
  output logic ready,
  output logic src_clk,
  output logic locked,
  output logic [7:0] edges
);
  logic busy;
  logic [7:0] cnt = 8'h00;
  initial {ready, src_clk, edges} = 10'h0;
  assign busy = target != current;
  // clock stands still until the source is ready; high phase 6 cycles
  always @(posedge pclk) begin
    if (!busy) begin
      cnt <= 8'h00;
      ready <= 1'b0;
      src_clk <= 1'b0;
      edges <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
      if (cnt == DLY) ready <= 1'b1;
      if (ready && cnt % 6 == 0) begin
        src_clk <= !src_clk;
        if (!src_clk) edges <= edges + 8'h01;
      end
    end
  end
  // lock only once a pll target is running
  assign locked = (target == 3'h1 || target == 3'h3) && (!busy || ready);
endmodule // oscdiv_osc_model

// file: verification/osc_select_and_clock_divider_bench.sv
`timescale 1ns/100ps
module osc_select_and_clock_divider_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdv;
  logic [2:0] init_sel = 3'h7;
  logic [1:0] post = 2'h1, psub = 2'h1;
  logic perm = 1'b0, irq = 1'b0, fail_ev = 1'b0, serr;
  wire [31:0] prdata;
  wire pready, pslverr, rdy, sclk, lck, sec_on, cpu_tick, periph_tick;
  wire [2:0] cur, pwr;
  wire [1:0] ptype;
  wire [8:0] frc_r;
  wire [3:0] vco_r;
  wire [5:0] pre_r;
  wire [9:0] fb_r;
  wire [7:0] edges;
  int err_count = 0, n_checks = 0, i, np;
  oscdiv_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .initial_osc_sel(init_sel), .primary_submode_sel(psub),
    .freeze_permission_cfg(perm), .new_src_ready(rdy), .new_src_clk(sclk),
    .pll_locked(lck), .clock_fail_event(fail_ev), .irq_pending(irq),
    .current_osc_sel(cur), .osc_power_sel(pwr), .primary_osc_type(ptype),
    .secondary_osc_on(sec_on), .fast_rc_div_ratio(frc_r), .vco_div_ratio(vco_r),
    .pre_div_ratio(pre_r), .feedback_multiplier(fb_r), .cpu_tick(cpu_tick),
    .periph_tick(periph_tick));
  oscdiv_osc_model osc (.pclk(pclk), .target(pwr), .current(cur), .ready(rdy),
    .src_clk(sclk), .locked(lck), .edges(edges));
  initial forever #2.5 pclk = ~pclk;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer, then an idle cycle so no signal is driven twice at once
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 16);
    rdv = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) begin err_count++; conclude(); end
    @(posedge pclk);
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, rdv, exp);
  endtask
  // key pair then the guarded write
  task ctl(input logic [31:0] d);
    xfer(1'b1, 8'h0c, 32'h46);
    xfer(1'b1, 8'h0c, 32'h57);
    xfer(1'b1, 8'h00, d);
  endtask
  task count_per(input int exp);
    repeat (4) @(posedge pclk);
    np = 0;
    repeat (512) begin @(posedge pclk); np += periph_tick; end
    chk("periph_count", np, exp);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdc("osc_ctrl", 8'h00, 32'h7700);
    rdc("clk_div", 8'h04, 32'h3040);
    rdc("fb_code", 8'h08, 32'h0030);
    chk("ptype", ptype, 2'h3);
    chk("fb", fb_r, 10'd50);
    rdc("unmapped", 8'h10, 32'h0);
    chk("slverr", serr, 1'b1);
    xfer(1'b1, 8'h00, 32'h0002);
    rdc("osc_ctrl", 8'h00, 32'h7700);
    // freeze without permission still lets dividers change
    ctl(32'h0780);
    xfer(1'b1, 8'h08, 32'hffffffff);
    rdc("fb_code", 8'h08, 32'h000001ff);
    chk("fb", fb_r, 10'd513);
    for (int c = 0; c < 8; c++) begin
      if (c[1:0] != 2'h2) post = c[1:0];
      xfer(1'b1, 8'h04, {16'hffff, 5'h0, c[2:0], c[1:0], 1'b1, c[2:0], 2'h3});
      rdc("clk_div", 8'h04, {21'h0, c[2:0], post, 1'b0, c[2:0], 2'h3});
      chk("frc", frc_r, (c == 7) ? 9'h100 : 9'h001 << c);
      chk("vco", vco_r, (post == 2'h3) ? 4'h8 : 4'h2 << post);
      chk("pre", pre_r, {c[2:0], 2'h3} + 2);
    end
    // every reduction code, then reduction off
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, 8'h04, {17'h0, c[2:0], 1'b1, 11'h040});
      count_per(256 >> c);
    end
    xfer(1'b1, 8'h04, 32'h7040);
    count_per(256);
    // interrupt clears reduction only when armed
    xfer(1'b1, 8'h04, 32'h3840);
    irq <= 1'b1;
    repeat (8) @(posedge pclk);
    rdc("clk_div", 8'h04, 32'h3840);
    xfer(1'b1, 8'h04, 32'hb840);
    repeat (8) @(posedge pclk);
    irq <= 1'b0;
    rdc("clk_div", 8'h04, 32'hb040);
    // same source request drops at once
    ctl(32'h0781);
    repeat (4) @(posedge pclk);
    rdc("osc_ctrl", 8'h00, 32'h7780);
    // fail flag set by hardware, cleared by software
    fail_ev <= 1'b1;
    repeat (8) @(posedge pclk);
    fail_ev <= 1'b0;
    repeat (6) @(posedge pclk);
    rdc("osc_ctrl", 8'h00, 32'h7788);
    ctl(32'h0782);
    rdc("osc_ctrl", 8'h00, 32'h7782);
    chk("sec_on", sec_on, 1'b1);
    // switch to primary with pll, legal from divide-by-n
    ctl(32'h0382);
    ctl(32'h0383);
    // request starts the switch one edge later, power select follows one more
    repeat (2) @(posedge pclk);
    chk("power_sel", pwr, 3'h3);
    i = 0;
    while (cur !== 3'h3 && i < 400) begin @(posedge pclk); i++; end
    if (i >= 400) begin err_count++; conclude(); end
    chk("src_edges", edges, 8'd10);
    repeat (3) @(posedge pclk);
    rdc("osc_ctrl", 8'h00, 32'h33a2);
    chk("ptype", ptype, 2'h1);
    psub <= 2'h2;
    repeat (2) @(posedge pclk);
    chk("ptype_hs", ptype, 2'h2);
    // reset again with permission, new strap, then freeze
    presetn <= 1'b0;
    perm <= 1'b1;
    init_sel <= 3'h5;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdc("osc_ctrl", 8'h00, 32'h5500);
    ctl(32'h0580);
    ctl(32'h0081);
    rdc("osc_ctrl", 8'h00, 32'h5580);
    xfer(1'b1, 8'h04, 32'h0340);
    // cpu_clock_reduction field stays writable under freeze, postscale does not
    rdc("clk_div", 8'h04, 32'h0040);
    conclude();
  end
endmodule // osc_select_and_clock_divider_bench
